// File: common/seq_ctrl_pkg.sv
// Constants shared by the converter sequencer global control logic
package seq_ctrl_pkg;
  localparam int unsigned ADDR_W    = 8;
  localparam int unsigned DATA_W    = 32;
  localparam int unsigned GROUPS    = 8;
  localparam int unsigned TMR_W     = 24;
  localparam int unsigned PRE_W     = 7;
  // Register byte offsets in the local register space
  localparam logic [ADDR_W-1:0] CTRL_OFS = 8'h88;
  localparam logic [ADDR_W-1:0] STAT_OFS = 8'h8C;
  // Control word field positions
  localparam int unsigned GATE_BIT  = 8;
  localparam int unsigned RUN_LSB   = 0;
  // Status nibble layout, low bit first
  localparam int unsigned NIB_W     = 4;
  localparam int unsigned BUSY_POS  = 0;
  localparam int unsigned SETF_POS  = 1;
  localparam int unsigned REQ_POS   = 2;
  localparam int unsigned UND_POS   = 3;
  // Reset values
  localparam logic [GROUPS-1:0] RUN_RST  = 8'h00;
  localparam logic              GATE_RST = 1'b0;
  localparam logic [GROUPS-1:0] FLAG_RST = 8'h00;
  localparam logic [DATA_W-1:0] ZERO_W   = 32'h0000_0000;
  // Timer base: one timer step lasts TICK_US microseconds
  localparam int unsigned CLK_MHZ   = 10;
  localparam int unsigned TICK_US   = 10;
  localparam int unsigned TICK_CYC  = TICK_US * CLK_MHZ;
  localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(TICK_CYC - 1);
  localparam logic [PRE_W-1:0] PRE_ZERO = 7'h00;
  localparam logic [PRE_W-1:0] PRE_ONE  = 7'h01;
  localparam logic [TMR_W-1:0] TMR_ZERO = 24'h00_0000;
  localparam logic [TMR_W-1:0] TMR_ONE  = 24'h00_0001;
endpackage : seq_ctrl_pkg

// File: logic/seq_global_ctrl.sv
// Global sequencer control, status word and interrupt gate for 8 groups
`timescale 1ns/10ps
`default_nettype none
module seq_global_ctrl (
  input  wire logic                                        clk_i,
  input  wire logic                                        rst_i,
  input  wire logic [seq_ctrl_pkg::ADDR_W-1:0]             reg_addr_i,
  input  wire logic                                        reg_wr_i,
  input  wire logic                                        reg_rd_i,
  input  wire logic [seq_ctrl_pkg::DATA_W-1:0]             reg_wdata_i,
  output logic      [seq_ctrl_pkg::DATA_W-1:0]             reg_rdata_o,
  input  wire logic [seq_ctrl_pkg::GROUPS-1:0][seq_ctrl_pkg::TMR_W-1:0]
                                                           timer_preload_i,
  input  wire logic [seq_ctrl_pkg::GROUPS-1:0]             group_irq_en_i,
  output logic      [seq_ctrl_pkg::GROUPS-1:0]             xfer_req_o,
  input  wire logic [seq_ctrl_pkg::GROUPS-1:0]             xfer_done_i,
  output logic                                             irq_o
);
  localparam int unsigned G = seq_ctrl_pkg::GROUPS;

  logic                              master_irq_gate_ff;
  logic [G-1:0]                      run_ff;
  logic [G-1:0]                      busy_ff;
  logic [G-1:0]                      set_flag_ff;
  logic [G-1:0]                      req_ff;
  logic [G-1:0]                      und_ff;
  logic [G-1:0]                      xfer_ff;
  logic [G-1:0][seq_ctrl_pkg::TMR_W-1:0] cnt_ff;
  logic [seq_ctrl_pkg::PRE_W-1:0]    pre_ff;
  logic                              tick_w;
  logic                              wr_ctrl_w;
  logic                              wr_stat_w;
  logic [G-1:0]                      fetch_w;
  logic [G-1:0]                      clr_req_w;
  logic [G-1:0]                      clr_und_w;

  // Packs the per-group flags into the status word layout
  function automatic logic [seq_ctrl_pkg::DATA_W-1:0] pack_status(
    input logic [G-1:0] und, input logic [G-1:0] req,
    input logic [G-1:0] setf, input logic [G-1:0] busy);
    logic [seq_ctrl_pkg::DATA_W-1:0] w;
    w = seq_ctrl_pkg::ZERO_W;
    for (int i = 0; i < G; i++) begin
      w[i*seq_ctrl_pkg::NIB_W + seq_ctrl_pkg::UND_POS]  = und[i];
      w[i*seq_ctrl_pkg::NIB_W + seq_ctrl_pkg::REQ_POS]  = req[i];
      w[i*seq_ctrl_pkg::NIB_W + seq_ctrl_pkg::SETF_POS] = setf[i];
      w[i*seq_ctrl_pkg::NIB_W + seq_ctrl_pkg::BUSY_POS] = busy[i];
    end
    return w;
  endfunction : pack_status

  // Extracts one flag column from a status word
  function automatic logic [G-1:0] col_of(
    input logic [seq_ctrl_pkg::DATA_W-1:0] w, input int unsigned pos);
    logic [G-1:0] c;
    c = '0;
    for (int i = 0; i < G; i++) begin
      c[i] = w[i*seq_ctrl_pkg::NIB_W + pos];
    end
    return c;
  endfunction : col_of

  // Register decode
  assign wr_ctrl_w = reg_wr_i && (reg_addr_i == seq_ctrl_pkg::CTRL_OFS);
  assign wr_stat_w = reg_wr_i && (reg_addr_i == seq_ctrl_pkg::STAT_OFS);
  assign clr_req_w = wr_stat_w ? col_of(reg_wdata_i, seq_ctrl_pkg::REQ_POS)
                               : '0;
  assign clr_und_w = wr_stat_w ? col_of(reg_wdata_i, seq_ctrl_pkg::UND_POS)
                               : '0;

  // Global control word; one write may start several groups at once
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      master_irq_gate_ff <= seq_ctrl_pkg::GATE_RST;
      run_ff             <= seq_ctrl_pkg::RUN_RST;
    end else if (wr_ctrl_w) begin
      master_irq_gate_ff <= reg_wdata_i[seq_ctrl_pkg::GATE_BIT];
      run_ff <= reg_wdata_i[seq_ctrl_pkg::RUN_LSB +: G];
    end
  end

  // Shared 10 us time base
  assign tick_w = (pre_ff == seq_ctrl_pkg::PRE_LAST);
  always_ff @(posedge clk_i) begin
    if (rst_i || tick_w) begin
      pre_ff <= seq_ctrl_pkg::PRE_ZERO;
    end else begin
      pre_ff <= pre_ff + seq_ctrl_pkg::PRE_ONE;
    end
  end

  // A fetch happens when a running group's interval expires
  always_comb begin
    for (int i = 0; i < G; i++) begin
      fetch_w[i] = tick_w && busy_ff[i] && run_ff[i] && !xfer_ff[i] &&
                   (cnt_ff[i] == seq_ctrl_pkg::TMR_ZERO);
    end
  end

  // Per-group sequencer: busy, interval counter and transfer state
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      busy_ff     <= seq_ctrl_pkg::FLAG_RST;
      xfer_ff     <= seq_ctrl_pkg::FLAG_RST;
      set_flag_ff <= seq_ctrl_pkg::FLAG_RST;
      cnt_ff      <= '0;
    end else begin
      for (int i = 0; i < G; i++) begin
        if (run_ff[i] && !busy_ff[i]) begin
          busy_ff[i] <= 1'b1;
          cnt_ff[i]  <= timer_preload_i[i];
        end else if (!run_ff[i] && !xfer_ff[i]) begin
          busy_ff[i]     <= 1'b0;
          set_flag_ff[i] <= 1'b0;
        end else if (fetch_w[i]) begin
          cnt_ff[i] <= timer_preload_i[i];
        end else if (tick_w && busy_ff[i] &&
                     cnt_ff[i] != seq_ctrl_pkg::TMR_ZERO) begin
          cnt_ff[i] <= cnt_ff[i] - seq_ctrl_pkg::TMR_ONE;
        end
        if (fetch_w[i]) begin
          xfer_ff[i] <= 1'b1;
        end else if (xfer_ff[i] && xfer_done_i[i]) begin
          xfer_ff[i]     <= 1'b0;
          set_flag_ff[i] <= 1'b1;
        end
      end
    end
  end

  // Clearable flags; a new event wins over a clear in the same cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      req_ff <= seq_ctrl_pkg::FLAG_RST;
      und_ff <= seq_ctrl_pkg::FLAG_RST;
    end else begin
      req_ff <= fetch_w | (req_ff & ~clr_req_w);
      und_ff <= (fetch_w & req_ff) | (und_ff & ~clr_und_w);
    end
  end

  // Registered read data; reserved and unmapped bits read as zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      reg_rdata_o <= seq_ctrl_pkg::ZERO_W;
    end else if (reg_rd_i && reg_addr_i == seq_ctrl_pkg::CTRL_OFS) begin
      reg_rdata_o <= seq_ctrl_pkg::ZERO_W;
      reg_rdata_o[seq_ctrl_pkg::GATE_BIT] <= master_irq_gate_ff;
      reg_rdata_o[seq_ctrl_pkg::RUN_LSB +: G] <= run_ff;
    end else if (reg_rd_i && reg_addr_i == seq_ctrl_pkg::STAT_OFS) begin
      reg_rdata_o <= pack_status(und_ff, req_ff, set_flag_ff, busy_ff);
    end else if (reg_rd_i) begin
      reg_rdata_o <= seq_ctrl_pkg::ZERO_W;
    end
  end

  // Handshake and interrupt outputs
  assign xfer_req_o = xfer_ff;
  assign irq_o = master_irq_gate_ff &&
                 (|((und_ff | req_ff) & group_irq_en_i));

  // Checks
  irq_gate_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !master_irq_gate_ff |-> !irq_o)
    else $error("interrupt passed a closed gate");
  irq_source_a: assert property (@(posedge clk_i) disable iff (rst_i)
    irq_o |-> |((und_ff | req_ff) & group_irq_en_i))
    else $error("interrupt without enabled event");
  ctrl_reset_a: assert property (@(posedge clk_i)
    rst_i |=> (run_ff == seq_ctrl_pkg::RUN_RST) && !master_irq_gate_ff)
    else $error("control word not reset");
  run_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_ctrl_w |=> run_ff == $past(reg_wdata_i[G-1:0]))
    else $error("run bits did not follow write");
  busy_run_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ##1 ((run_ff & $past(run_ff) & ~busy_ff) == '0))
    else $error("busy low while running");
  stop_wait_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ##1 (($past(busy_ff) & ~busy_ff & $past(xfer_ff)) == '0))
    else $error("busy dropped during transfer");
  ctrl_rsvd_a: assert property (@(posedge clk_i) disable iff (rst_i)
    reg_rd_i && reg_addr_i == seq_ctrl_pkg::CTRL_OFS
    |=> reg_rdata_o[seq_ctrl_pkg::DATA_W-1:seq_ctrl_pkg::GATE_BIT+1] == '0)
    else $error("reserved control bits not zero");
  stat_map_a: assert property (@(posedge clk_i) disable iff (rst_i)
    reg_rd_i && reg_addr_i == seq_ctrl_pkg::STAT_OFS
    |=> reg_rdata_o == pack_status($past(und_ff), $past(req_ff),
                                   $past(set_flag_ff), $past(busy_ff)))
    else $error("status word layout wrong");
  flag_reset_a: assert property (@(posedge clk_i)
    rst_i |=> (req_ff == '0) && (und_ff == '0))
    else $error("status flags not reset");
  under_set_a: assert property (@(posedge clk_i) disable iff (rst_i)
    |(fetch_w & req_ff)
    |=> (($past(fetch_w & req_ff) & ~(und_ff & xfer_ff)) == '0))
    else $error("underflow not flagged");
  flag_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ##1 (req_ff == ($past(fetch_w) | ($past(req_ff) & ~$past(clr_req_w)))))
    else $error("request flag clear wrong");
  reload_a: assert property (@(posedge clk_i) disable iff (rst_i)
    fetch_w[0] |=> cnt_ff[0] == $past(timer_preload_i[0]))
    else $error("interval not reloaded");
  fetch_cv: cover property (@(posedge clk_i) disable iff (rst_i)
    fetch_w[0] ##[1:200] xfer_done_i[0] && xfer_ff[0]);
  stop_cv: cover property (@(posedge clk_i) disable iff (rst_i)
    xfer_ff[0] && !run_ff[0] ##[1:50] !busy_ff[0]);
  under_cv: cover property (@(posedge clk_i) disable iff (rst_i)
    $rose(|und_ff));
  irq_cv: cover property (@(posedge clk_i) disable iff (rst_i) $rose(irq_o));
endmodule : seq_global_ctrl
`default_nettype wire

// File: bench/testbench.sv
// Self-checking testbench for the sequencer global control block
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, exp, got) begin n_compared++; if ((got) !== (exp)) begin \
  n_errors++; $display("[ERR] %s exp %h got %h", nm, exp, got); end end
module testbench;
  localparam logic [7:0] CO = seq_ctrl_pkg::CTRL_OFS;
  localparam logic [7:0] SO = seq_ctrl_pkg::STAT_OFS;
  logic               clk_i;
  logic               rst_i;
  logic [7:0]         reg_addr_i;
  logic               reg_wr_i;
  logic               reg_rd_i;
  logic [31:0]        reg_wdata_i;
  logic [31:0]        reg_rdata_o;
  logic [7:0][23:0]   timer_preload_i;
  logic [7:0]         group_irq_en_i;
  logic [7:0]         xfer_req_o;
  logic [7:0]         xfer_done_i;
  logic               irq_o;
  int                 n_errors;
  int                 n_compared;
  int                 cyc;
  int                 t_rise;
  int                 t_prev;

  seq_global_ctrl i_dut (.clk_i(clk_i), .rst_i(rst_i),
    .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
    .timer_preload_i(timer_preload_i), .group_irq_en_i(group_irq_en_i),
    .xfer_req_o(xfer_req_o), .xfer_done_i(xfer_done_i), .irq_o(irq_o));

  // Clock of 100 ns period
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end

  // Cycle count with a ceiling against hangs
  always @(posedge clk_i) begin
    cyc++;
    if (cyc >= 20000) begin
      n_errors++;
      results();
    end
  end

  // Register write: strobe held for one edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(negedge clk_i);
    reg_addr_i  = a;
    reg_wdata_i = d;
    reg_wr_i    = 1'b1;
    @(negedge clk_i);
    reg_wr_i    = 1'b0;
    @(negedge clk_i);
  endtask : wr

  // Register read and compare
  task automatic chk_reg(input logic [7:0] a, input logic [31:0] e);
    @(negedge clk_i);
    reg_addr_i = a;
    reg_rd_i   = 1'b1;
    @(negedge clk_i);
    reg_rd_i   = 1'b0;
    @(negedge clk_i);
    `CHK("reg", e, reg_rdata_o)
  endtask : chk_reg

  // Wait for a transfer request of group g, bounded
  task automatic wait_req(input int g);
    int n;
    n = 0;
    while (xfer_req_o[g] !== 1'b1 && n < 400) begin
      @(negedge clk_i);
      n++;
    end
    t_prev = t_rise;
    t_rise = cyc;
    `CHK("xfer_req", 1'b1, xfer_req_o[g])
  endtask : wait_req

  // Transfer completion pulse for the groups in m
  task automatic done(input logic [7:0] m);
    @(negedge clk_i);
    xfer_done_i = m;
    @(negedge clk_i);
    xfer_done_i = 8'h00;
    `CHK("req_drop", 8'h00, xfer_req_o & m)
  endtask : done

  task automatic t_reset();
    chk_reg(CO, 32'h0000_0000);
    chk_reg(SO, 32'h0000_0000);
    `CHK("irq", 1'b0, irq_o)
    wr(CO, 32'h0000_0100);
    chk_reg(CO, 32'h0000_0100);
    chk_reg(8'h90, 32'h0000_0000);
    $display("test reset/ctrl done");
  endtask : t_reset

  task automatic t_timed();
    wr(CO, 32'h0000_0102);
    chk_reg(SO, 32'h0000_0010);
    wait_req(1);
    chk_reg(SO, 32'h0000_0050);
    `CHK("irq", 1'b1, irq_o)
    done(8'h02);
    wr(SO, 32'h0000_0000);
    chk_reg(SO, 32'h0000_0070);
    wr(SO, 32'h0000_0040);
    chk_reg(SO, 32'h0000_0030);
    `CHK("irq", 1'b0, irq_o)
    wait_req(1);
    `CHK("interval", 200, t_rise - t_prev)
    done(8'h02);
    wait_req(1);
    chk_reg(SO, 32'h0000_00F0);
    group_irq_en_i = 8'hFD;
    @(negedge clk_i);
    `CHK("irq", 1'b0, irq_o)
    group_irq_en_i = 8'hFF;
    wr(CO, 32'h0000_0002);
    `CHK("irq", 1'b0, irq_o)
    $display("test timed done");
  endtask : t_timed

  task automatic t_stop();
    wr(CO, 32'h0000_0000);
    repeat (5) @(negedge clk_i);
    `CHK("xfer_req", 1'b1, xfer_req_o[1])
    chk_reg(SO, 32'h0000_00F0);
    done(8'h02);
    chk_reg(SO, 32'h0000_00C0);
    wr(SO, 32'h0000_00C0);
    chk_reg(SO, 32'h0000_0000);
    $display("test stop done");
  endtask : t_stop

  task automatic t_multi();
    wr(CO, 32'h0000_00FF);
    chk_reg(SO, 32'h1111_1111);
    wait_req(0);
    `CHK("xfer_all", 8'hFF, xfer_req_o)
    chk_reg(SO, 32'h5555_5555);
    wr(CO, 32'h0000_0000);
    done(8'hFF);
    chk_reg(SO, 32'h4444_4444);
    wr(SO, 32'hFFFF_FFFF);
    chk_reg(SO, 32'h0000_0000);
    $display("test multi done");
  endtask : t_multi

  // Reset in mid-run while a transfer is still pending
  task automatic t_rst_mid();
    wr(CO, 32'h0000_0101);
    wait_req(0);
    `CHK("irq", 1'b1, irq_o)
    rst_i = 1'b1;
    repeat (3) @(negedge clk_i);
    rst_i = 1'b0;
    `CHK("xfer_req", 8'h00, xfer_req_o)
    `CHK("irq", 1'b0, irq_o)
    chk_reg(CO, 32'h0000_0000);
    chk_reg(SO, 32'h0000_0000);
    $display("test mid reset done");
  endtask : t_rst_mid

  // Verdict and end of run
  task automatic results();
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : results

  // Main sequence
  initial begin
    rst_i           = 1'b1;
    reg_addr_i      = 8'h00;
    reg_wr_i        = 1'b0;
    reg_rd_i        = 1'b0;
    reg_wdata_i     = 32'h0000_0000;
    timer_preload_i = {8{24'h00_0001}};
    group_irq_en_i  = 8'hFF;
    xfer_done_i     = 8'h00;
    repeat (5) @(negedge clk_i);
    rst_i = 1'b0;
    t_reset();
    t_timed();
    t_stop();
    t_multi();
    t_rst_mid();
    results();
  end
endmodule : testbench
`default_nettype wire
